// ---- pmx_pkg.sv ----
// constants for the port mac and xmii configuration bank
package pmx_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int IDX_W  = 14;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_XMII_CTL0 = 14'h3300;
  localparam logic [IDX_W-1:0] IDX_XMII_CTL1 = 14'h3301;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h3302;
  localparam logic [IDX_W-1:0] IDX_MAC_CTL0  = 14'h1400;
  localparam logic [IDX_W-1:0] IDX_MAC_CTL1  = 14'h1401;

  // xmii port control zero
  localparam int XC0_DUPLEX = 6;
  localparam int XC0_TXFC   = 5;
  localparam int XC0_SPD100 = 4;
  localparam int XC0_RXFC   = 3;
  // xmii port control one
  localparam int XC1_SPD1G  = 6;
  localparam int XC1_RXDLY  = 4;
  localparam int XC1_TXDLY  = 3;
  localparam int XC1_MODE   = 2;
  localparam int XC1_TYPE   = 0;
  // port mac control zero / one
  localparam int MC0_STORM  = 1;
  localparam int MC0_JUMBO  = 0;
  localparam int MC1_BP     = 3;
  localparam int MC1_PASS   = 0;

  localparam logic [REG_W-1:0] XC0_RST   = 8'h50;
  localparam logic [REG_W-1:0] XC1_RST   = 8'h08;
  localparam logic [REG_W-1:0] MC0_RST   = 8'h00;
  localparam logic [REG_W-1:0] MC1_RST   = 8'h00;
  localparam logic [REG_W-1:0] XC0_WMASK = 8'h7f;
  localparam logic [REG_W-1:0] XC1_WMASK = 8'hff;
  localparam logic [REG_W-1:0] MC0_WMASK = 8'h0b;
  localparam logic [REG_W-1:0] MC1_WMASK = 8'hbf;

  // interface type codes
  localparam logic [1:0] IF_MII   = 2'h0;
  localparam logic [1:0] IF_RMII  = 2'h1;
  localparam logic [1:0] IF_RSVD  = 2'h2;
  localparam logic [1:0] IF_RGMII = 2'h3;

  // speed codes
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // frame size limits in bytes
  localparam int FRAME_OVERHEAD = 18;
  localparam int STD_PAYLOAD    = 1500;
  localparam int JUMBO_PAYLOAD  = 9000;
  localparam int MIN_FRAME      = 64;
  localparam int LEN_W          = 14;

  // least clock delay inserted by the external delay cells
  localparam int CLK_DELAY_MIN_PS = 1500;

  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // configuration bits carried into the link domain
  localparam int CFG_W      = 8;
  localparam int CFG_DUPLEX = 0;
  localparam int CFG_TXFC   = 1;
  localparam int CFG_RXFC   = 2;
  localparam int CFG_BP     = 3;
  localparam int CFG_PASS   = 4;
  localparam int CFG_JUMBO  = 5;
  localparam int CFG_STORM  = 6;
  localparam int CFG_CONG   = 7;

endpackage

// ---- pmx_port_config.sv ----
// per-port mac and xmii configuration bank with link-side frame policing
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - duplex bit set means full duplex, clear half; resets to one
// - transmit flow control only while its enable bit is one; resets zero
// - gigabit field selecting 1000 makes the 10/100 bit ignored
// - 10/100 bit one gives 100 Mb/s, zero gives 10; resets one
// - receive flow control only while its enable bit is one; resets zero
// - gigabit field zero runs 1000 Mb/s, one defers to 10/100 bit
// - ingress delay bit adds at least 1.5 ns to receive clock
// - egress delay bit adds at least 1.5 ns to transmit clock; resets one
// - mii: mode one takes clocks as mac, zero drives clocks as phy
// - rmii: mode one receives 50 MHz reference, zero generates it
// - type field: 00 mii, 01 rmii, 11 rgmii, 10 reserved
// - mode bit and type field reset values come from strap pins
// - broadcast storm protection on ingress only while its enable is one
// - jumbo allows 9000-byte payload, otherwise 1500-byte payload limit
// - back pressure only in half duplex and only when enabled
// - bad frames dropped unless pass-all, then forwarded for mirroring only
// - flow-control frame filtering does not depend on pass-all
module pmx_port_config
  import pmx_pkg::*;
#(
  parameter int STORM_WINDOW = 1000,
  parameter int STORM_LIMIT  = 8
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              modeStrapPin,
  input  wire logic [1:0]        typeStrapPin,
  input  wire logic              bufCongested,
  output logic                   fullDuplex,
  output logic      [1:0]        speedSel,
  output logic      [1:0]        ifType,
  output logic                   miiMacMode,
  output logic                   rxClkPinOe,
  output logic                   refClkGenEn,
  output logic                   rxClockDelayEnable,
  output logic                   txClockDelayEnable,
  output logic                   jumboEn,
  input  wire logic              linkClk,
  input  wire logic              frameByte,
  input  wire logic              frameEnd,
  input  wire logic              frameCrcErr,
  input  wire logic              frameBcast,
  input  wire logic              frameIsPause,
  input  wire logic              pauseFilterEn,
  input  wire logic              pauseRcvd,
  output logic                   frameForward,
  output logic                   frameMirrorOnly,
  output logic                   frameDrop,
  output logic                   pauseTx,
  output logic                   jamTx,
  output logic                   txHold
);

  localparam int WIN_W = $clog2(STORM_WINDOW + 1);
  localparam int LIM_W = $clog2(STORM_LIMIT + 1);
  localparam logic [LEN_W-1:0] MAX_STD   = LEN_W'(STD_PAYLOAD + FRAME_OVERHEAD);
  localparam logic [LEN_W-1:0] MAX_JUMBO = LEN_W'(JUMBO_PAYLOAD + FRAME_OVERHEAD);
  localparam logic [LEN_W-1:0] MIN_LEN   = LEN_W'(MIN_FRAME);
  localparam logic [WIN_W-1:0] WIN_END   = WIN_W'(STORM_WINDOW - 1);
  localparam logic [LIM_W-1:0] LIM_VAL   = LIM_W'(STORM_LIMIT);

  typedef enum logic [2:0] {
    PMX_SEL_NONE,
    PMX_SEL_XC0,
    PMX_SEL_XC1,
    PMX_SEL_STAT,
    PMX_SEL_MC0,
    PMX_SEL_MC1
  } pmx_sel_t;

  typedef struct packed {
    logic [REG_W-1:0]  xc0;
    logic [REG_W-1:0]  xc1;
    logic [REG_W-1:0]  mc0;
    logic [REG_W-1:0]  mc1;
    logic [2:0]        strapS1;
    logic [2:0]        strapS2;
    logic [1:0]        strapCnt;
    logic              strapDone;
    logic [DATA_W-1:0] rdData;
    logic [CFG_W-1:0]  cfg;
    logic              fullDuplex;
    logic [1:0]        speedSel;
    logic [1:0]        ifType;
    logic              miiMacMode;
    logic              rxClkPinOe;
    logic              refClkGenEn;
    logic              rxDly;
    logic              txDly;
    logic              jumbo;
  } pmx_sys_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfgS1;
    logic [CFG_W-1:0] cfgS2;
    logic             pfS1;
    logic             pfS2;
    logic [LEN_W-1:0] byteCnt;
    logic [WIN_W-1:0] winCnt;
    logic [LIM_W-1:0] bcastCnt;
    logic             fwd;
    logic             mirror;
    logic             drop;
    logic             pauseTx;
    logic             jam;
    logic             hold;
  } pmx_link_t;

  pmx_sys_t  sys_r;
  pmx_sys_t  sys_nxt;
  pmx_link_t lnk_r;
  pmx_link_t lnk_nxt;

  logic rstS1_r;
  logic rstS2_r;
  logic lrstS1_r;
  logic lrstS2_r;

  // one decode used by both the write and the read path
  function automatic pmx_sel_t decodeSel(input logic [ADDR_W-1:0] a);
    pmx_sel_t s;
    s = PMX_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[ADDR_W-1:2])
        IDX_XMII_CTL0: s = PMX_SEL_XC0;
        IDX_XMII_CTL1: s = PMX_SEL_XC1;
        IDX_STATUS:    s = PMX_SEL_STAT;
        IDX_MAC_CTL0:  s = PMX_SEL_MC0;
        IDX_MAC_CTL1:  s = PMX_SEL_MC1;
        default:       s = PMX_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [REG_W-1:0] mergeWr(input logic [REG_W-1:0] old,
                                                input logic [REG_W-1:0] wd,
                                                input logic [REG_W-1:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  // system reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstS1_r <= 1'b0;
      rstS2_r <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstS2_r <= rstS1_r;
    end
  end

  // link reset released on the link clock; asserted at once
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      lrstS1_r <= 1'b0;
      lrstS2_r <= 1'b0;
    end else begin
      lrstS1_r <= rstS2_r;
      lrstS2_r <= lrstS1_r;
    end
  end

  // system domain next state
  always_comb begin
    pmx_sel_t         wSel;
    pmx_sel_t         rSel;
    logic [REG_W-1:0] newXc1;
    logic [1:0]       typ;
    logic             mode;
    wSel    = decodeSel(addr);
    rSel    = wSel;
    newXc1  = sys_r.xc1;
    typ     = sys_r.xc1[XC1_TYPE+:2];
    mode    = sys_r.xc1[XC1_MODE];
    sys_nxt = sys_r;

    sys_nxt.strapS1 = {modeStrapPin, typeStrapPin};
    sys_nxt.strapS2 = sys_r.strapS1;

    // straps sampled once, after the synchroniser has settled
    if (!sys_r.strapDone) begin
      if (sys_r.strapCnt == STRAP_SETTLE) begin
        sys_nxt.strapDone              = 1'b1;
        sys_nxt.xc1[XC1_MODE]          = sys_r.strapS2[2];
        sys_nxt.xc1[XC1_TYPE+:2]       = sys_r.strapS2[1:0];
      end else begin
        sys_nxt.strapCnt = sys_r.strapCnt + 2'h1;
      end
    end else if (wrStb) begin
      case (wSel)
        PMX_SEL_XC0: sys_nxt.xc0 = mergeWr(sys_r.xc0, wrData[REG_W-1:0], XC0_WMASK);
        PMX_SEL_XC1: begin
          newXc1 = mergeWr(sys_r.xc1, wrData[REG_W-1:0], XC1_WMASK);
          // reserved interface code is refused, the old type stays
          if (newXc1[XC1_TYPE+:2] == IF_RSVD) begin
            newXc1[XC1_TYPE+:2] = sys_r.xc1[XC1_TYPE+:2];
          end
          sys_nxt.xc1 = newXc1;
        end
        PMX_SEL_MC0: sys_nxt.mc0 = mergeWr(sys_r.mc0, wrData[REG_W-1:0], MC0_WMASK);
        PMX_SEL_MC1: sys_nxt.mc1 = mergeWr(sys_r.mc1, wrData[REG_W-1:0], MC1_WMASK);
        default: begin
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    sys_nxt.rdData = '0;
    if (rdStb) begin
      case (rSel)
        PMX_SEL_XC0:  sys_nxt.rdData = {{(DATA_W-REG_W){1'b0}}, sys_r.xc0};
        PMX_SEL_XC1:  sys_nxt.rdData = {{(DATA_W-REG_W){1'b0}}, sys_r.xc1};
        PMX_SEL_MC0:  sys_nxt.rdData = {{(DATA_W-REG_W){1'b0}}, sys_r.mc0};
        PMX_SEL_MC1:  sys_nxt.rdData = {{(DATA_W-REG_W){1'b0}}, sys_r.mc1};
        PMX_SEL_STAT: sys_nxt.rdData = {{(DATA_W-8){1'b0}}, sys_r.strapDone,
                                        sys_r.rxClkPinOe, sys_r.refClkGenEn,
                                        sys_r.fullDuplex, sys_r.speedSel,
                                        sys_r.ifType};
        default:      sys_nxt.rdData = '0;
      endcase
    end

    // decoded controls, one cycle behind the register bits
    sys_nxt.fullDuplex = sys_r.xc0[XC0_DUPLEX];
    if (!sys_r.xc1[XC1_SPD1G]) begin
      sys_nxt.speedSel = SPD_1000;
    end else if (sys_r.xc0[XC0_SPD100]) begin
      sys_nxt.speedSel = SPD_100;
    end else begin
      sys_nxt.speedSel = SPD_10;
    end
    sys_nxt.ifType      = typ;
    sys_nxt.miiMacMode  = (typ == IF_MII) && mode;
    sys_nxt.refClkGenEn = (typ == IF_RMII) && !mode;
    // the clock pin is an output for mii phy role and rmii generation
    case (typ)
      IF_MII:  sys_nxt.rxClkPinOe = !mode;
      IF_RMII: sys_nxt.rxClkPinOe = !mode;
      default: sys_nxt.rxClkPinOe = 1'b0;
    endcase
    // delay is made by pad delay cells; logic only selects them
    sys_nxt.rxDly = (typ == IF_RGMII) && sys_r.xc1[XC1_RXDLY];
    sys_nxt.txDly = (typ == IF_RGMII) && sys_r.xc1[XC1_TXDLY];
    sys_nxt.jumbo = sys_r.mc0[MC0_JUMBO];

    sys_nxt.cfg[CFG_DUPLEX] = sys_r.xc0[XC0_DUPLEX];
    sys_nxt.cfg[CFG_TXFC]   = sys_r.xc0[XC0_TXFC];
    sys_nxt.cfg[CFG_RXFC]   = sys_r.xc0[XC0_RXFC];
    sys_nxt.cfg[CFG_BP]     = sys_r.mc1[MC1_BP];
    sys_nxt.cfg[CFG_PASS]   = sys_r.mc1[MC1_PASS];
    sys_nxt.cfg[CFG_JUMBO]  = sys_r.mc0[MC0_JUMBO];
    sys_nxt.cfg[CFG_STORM]  = sys_r.mc0[MC0_STORM];
    sys_nxt.cfg[CFG_CONG]   = bufCongested;
  end

  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      sys_r             <= '0;
      sys_r.xc0         <= XC0_RST;
      sys_r.xc1         <= XC1_RST;
      sys_r.mc0         <= MC0_RST;
      sys_r.mc1         <= MC1_RST;
      sys_r.fullDuplex  <= 1'b1;
      sys_r.speedSel    <= SPD_1000;
      sys_r.txDly       <= 1'b0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // link domain next state
  always_comb begin
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] maxLen;
    logic             bad;
    logic             storm;
    logic             fdx;
    lnk_nxt = lnk_r;
    len     = lnk_r.byteCnt;
    maxLen  = MAX_STD;
    bad     = 1'b0;
    storm   = 1'b0;
    fdx     = lnk_r.cfgS2[CFG_DUPLEX];

    // configuration bits are static levels, two flops each
    lnk_nxt.cfgS1 = sys_r.cfg;
    lnk_nxt.cfgS2 = lnk_r.cfgS1;
    lnk_nxt.pfS1  = pauseFilterEn;
    lnk_nxt.pfS2  = lnk_r.pfS1;

    lnk_nxt.fwd    = 1'b0;
    lnk_nxt.mirror = 1'b0;
    lnk_nxt.drop   = 1'b0;

    // saturating count keeps oversize frames oversize
    if (frameByte && (lnk_r.byteCnt != {LEN_W{1'b1}})) begin
      len = lnk_r.byteCnt + LEN_W'(1);
    end
    lnk_nxt.byteCnt = len;

    // broadcast count restarts each window
    if (lnk_r.winCnt == WIN_END) begin
      lnk_nxt.winCnt   = '0;
      lnk_nxt.bcastCnt = '0;
    end else begin
      lnk_nxt.winCnt = lnk_r.winCnt + WIN_W'(1);
    end

    if (frameEnd) begin
      lnk_nxt.byteCnt = '0;
      if (lnk_r.cfgS2[CFG_JUMBO]) begin
        maxLen = MAX_JUMBO;
      end
      bad = frameCrcErr || (len > maxLen) || (len < MIN_LEN);
      if (frameBcast && lnk_r.cfgS2[CFG_STORM]) begin
        storm = (lnk_r.bcastCnt >= LIM_VAL);
        if (!storm && (lnk_r.winCnt != WIN_END)) begin
          lnk_nxt.bcastCnt = lnk_r.bcastCnt + LIM_W'(1);
        end
      end
      if (frameIsPause) begin
        // pause filtering follows the switch-wide control alone
        lnk_nxt.drop = lnk_r.pfS2;
        lnk_nxt.fwd  = !lnk_r.pfS2;
      end else if (bad) begin
        lnk_nxt.mirror = lnk_r.cfgS2[CFG_PASS];
        lnk_nxt.drop   = !lnk_r.cfgS2[CFG_PASS];
      end else if (storm) begin
        lnk_nxt.drop = 1'b1;
      end else begin
        lnk_nxt.fwd = 1'b1;
      end
    end

    lnk_nxt.pauseTx = fdx && lnk_r.cfgS2[CFG_TXFC] && lnk_r.cfgS2[CFG_CONG];
    lnk_nxt.jam     = !fdx && lnk_r.cfgS2[CFG_BP] && lnk_r.cfgS2[CFG_CONG];
    lnk_nxt.hold    = lnk_r.cfgS2[CFG_RXFC] && pauseRcvd;
  end

  always_ff @(posedge linkClk or negedge lrstS2_r) begin
    if (!lrstS2_r) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  assign rdData             = sys_r.rdData;
  assign fullDuplex         = sys_r.fullDuplex;
  assign speedSel           = sys_r.speedSel;
  assign ifType             = sys_r.ifType;
  assign miiMacMode         = sys_r.miiMacMode;
  assign rxClkPinOe         = sys_r.rxClkPinOe;
  assign refClkGenEn        = sys_r.refClkGenEn;
  assign rxClockDelayEnable = sys_r.rxDly;
  assign txClockDelayEnable = sys_r.txDly;
  assign jumboEn            = sys_r.jumbo;
  assign frameForward       = lnk_r.fwd;
  assign frameMirrorOnly    = lnk_r.mirror;
  assign frameDrop          = lnk_r.drop;
  assign pauseTx            = lnk_r.pauseTx;
  assign jamTx              = lnk_r.jam;
  assign txHold             = lnk_r.hold;

endmodule

`default_nettype wire

// ---- pmx_port_config_checker.sv ----
// concurrent checks on the port configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module pmx_port_config_checker
  import pmx_pkg::*;
#(
  parameter int STORM_WINDOW = 1000,
  parameter int STORM_LIMIT  = 8
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              rdStb,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              fullDuplex,
  input wire logic [1:0]        speedSel,
  input wire logic [1:0]        ifType,
  input wire logic              miiMacMode,
  input wire logic              rxClkPinOe,
  input wire logic              refClkGenEn,
  input wire logic              rxClockDelayEnable,
  input wire logic              txClockDelayEnable,
  input wire logic              linkClk,
  input wire logic              frameEnd,
  input wire logic              frameIsPause,
  input wire logic              pauseFilterEn,
  input wire logic              frameForward,
  input wire logic              frameMirrorOnly,
  input wire logic              frameDrop,
  input wire logic              pauseTx,
  input wire logic              jamTx
);
  a_read_idle_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(rdStb) |-> rdData == '0) else $error("read data outside read slot");
  a_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rdData[31:8] == '0) else $error("upper read data bits set");
  a_type_legal: assert property (@(posedge clk) disable iff (!reset_n)
    ifType != IF_RSVD) else $error("reserved interface type in use");
  a_speed_code: assert property (@(posedge clk) disable iff (!reset_n)
    speedSel != 2'h3) else $error("illegal speed code");
  a_mac_mode: assert property (@(posedge clk) disable iff (!reset_n)
    miiMacMode |-> ifType == IF_MII && !rxClkPinOe) else $error("mac mode clocks wrong");
  a_reduced_interface_reference_clock_gen: assert property (@(posedge clk) disable iff (!reset_n)
    refClkGenEn |-> ifType == IF_RMII && rxClkPinOe) else $error("reduced_interface_reference_clock source wrong");
  a_rx_delay: assert property (@(posedge clk) disable iff (!reset_n)
    rxClockDelayEnable |-> ifType == IF_RGMII) else $error("rx delay outside rgmii");
  a_tx_delay: assert property (@(posedge clk) disable iff (!reset_n)
    txClockDelayEnable |-> ifType == IF_RGMII) else $error("tx delay outside rgmii");
  a_pause_full: assert property (@(posedge clk) disable iff (!reset_n)
    pauseTx |-> fullDuplex) else $error("pause sent in half duplex");
  a_jam_half: assert property (@(posedge clk) disable iff (!reset_n)
    jamTx |-> !fullDuplex) else $error("back pressure in full duplex");
  a_one_verdict: assert property (@(posedge linkClk) disable iff (!reset_n)
    frameEnd |=> $onehot({frameForward, frameMirrorOnly, frameDrop}))
    else $error("frame without single verdict");
  a_no_stray: assert property (@(posedge linkClk) disable iff (!reset_n)
    frameForward || frameMirrorOnly || frameDrop |-> $past(frameEnd))
    else $error("verdict without frame end");
  a_pause_filter: assert property (@(posedge linkClk) disable iff (!reset_n)
    frameEnd && frameIsPause |=> frameDrop == $past(pauseFilterEn, 3)
    && frameForward == !$past(pauseFilterEn, 3)) else $error("pause frame verdict wrong");
endmodule
bind pmx_port_config pmx_port_config_checker #(
  .STORM_WINDOW(STORM_WINDOW), .STORM_LIMIT(STORM_LIMIT)) u_chk (
  .clk, .reset_n, .rdStb, .rdData, .fullDuplex, .speedSel, .ifType, .miiMacMode,
  .rxClkPinOe, .refClkGenEn, .rxClockDelayEnable, .txClockDelayEnable, .linkClk,
  .frameEnd, .frameIsPause, .pauseFilterEn, .frameForward, .frameMirrorOnly,
  .frameDrop, .pauseTx, .jamTx);
`default_nettype wire

// ---- pmx_link_partner.sv ----
// behavioural link partner feeding frames into the port
`timescale 1ns/1ps
`default_nettype none
module pmx_link_partner (
  input  wire logic linkClk,
  input  wire logic rxClkPinOe,
  output logic      ptnClkOe,
  output logic      frameByte,
  output logic      frameEnd,
  output logic      frameCrcErr,
  output logic      frameBcast,
  output logic      frameIsPause,
  output logic      pauseRcvd
);
  // never fight the device on the shared receive clock pin
  assign ptnClkOe = !rxClkPinOe;
  initial begin
    frameByte = 1'b0;
    frameEnd = 1'b0;
    frameCrcErr = 1'b0;
    frameBcast = 1'b0;
    frameIsPause = 1'b0;
    pauseRcvd = 1'b0;
  end
  task automatic send(input int len, input logic crc, bc, pse, input int gap);
    for (int i = 1; i <= len; i++) begin
      @(posedge linkClk);
      frameByte <= 1'b1;
      frameEnd <= (i == len);
      frameCrcErr <= crc;
      frameBcast <= bc;
      frameIsPause <= pse;
    end
    @(posedge linkClk);
    frameByte <= 1'b0;
    frameEnd <= 1'b0;
    // qualifiers mean nothing off the end cycle, so show the inverse
    frameCrcErr <= !crc;
    frameBcast <= !bc;
    frameIsPause <= !pse;
    repeat (gap) @(posedge linkClk);
  endtask
  task automatic setPause(input logic v);
    @(posedge linkClk);
    pauseRcvd <= v;
  endtask
endmodule
`default_nettype wire

// ---- pmx_port_config_tb.sv ----
// self-checking bench for the port configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module pmx_port_config_tb;
  import pmx_pkg::*;
  localparam logic [2:0] FWD = 3'h4;
  localparam logic [2:0] MIR = 3'h2;
  localparam logic [2:0] DRP = 3'h1;
  logic              clk, reset_n, linkClk, wrStb, rdStb, rdSeen, m;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData, rdExp;
  logic              modeStrapPin, bufCongested, pauseFilterEn, fullDuplex, miiMacMode;
  logic [1:0]        typeStrapPin, speedSel, ifType, t;
  logic              rxClkPinOe, refClkGenEn, rxClockDelayEnable, txClockDelayEnable, jumboEn;
  logic              frameByte, frameEnd, frameCrcErr, frameBcast, frameIsPause, pauseRcvd;
  logic              frameForward, frameMirrorOnly, frameDrop, pauseTx, jamTx, txHold, ptnClkOe;
  logic [2:0]        vExp;
  logic [7:0]        v;
  logic [DATA_W-1:0] rdQ[$];
  logic [2:0]        vQ[$];
  int                errors, compares, seed;

  pmx_port_config #(.STORM_WINDOW(1000), .STORM_LIMIT(2)) dut (
    .clk, .reset_n, .addr, .wrData, .wrStb, .rdStb, .rdData, .modeStrapPin, .typeStrapPin,
    .bufCongested, .fullDuplex, .speedSel, .ifType, .miiMacMode, .rxClkPinOe, .refClkGenEn,
    .rxClockDelayEnable, .txClockDelayEnable, .jumboEn, .linkClk, .frameByte, .frameEnd,
    .frameCrcErr, .frameBcast, .frameIsPause, .pauseFilterEn, .pauseRcvd, .frameForward,
    .frameMirrorOnly, .frameDrop, .pauseTx, .jamTx, .txHold);
  pmx_link_partner ptn (.linkClk, .rxClkPinOe, .ptnClkOe, .frameByte, .frameEnd,
    .frameCrcErr, .frameBcast, .frameIsPause, .pauseRcvd);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= {24'h00_0000, d};
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rdQ.push_back({24'h00_0000, e});
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic frm(input int len, input logic crc, bc, pse, input logic [2:0] e);
    vQ.push_back(e);
    ptn.send(len, crc, bc, pse, $random(seed) & 3);
  endtask
  task automatic congest(input logic [1:0] e);
    @(posedge clk);
    bufCongested <= 1'b1;
    settle();
    `CHK({pauseTx, jamTx}, e)
    bufCongested <= 1'b0;
    settle();
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // read data belong to the cycle after the strobe only
  always @(posedge clk) begin
    rdSeen <= rdStb;
    if (rdSeen) begin
      rdExp = rdQ.pop_front();
      `CHK(rdData, rdExp)
    end
  end
  always @(posedge linkClk) begin
    if (frameForward || frameMirrorOnly || frameDrop) begin
      vExp = vQ.pop_front();
      `CHK({frameForward, frameMirrorOnly, frameDrop}, vExp)
    end
  end
  initial begin
    #400_000;
    errors++;
    report_and_stop();
  end

  initial begin
    seed = 3;
    errors = 0;
    compares = 0;
    {reset_n, wrStb, rdStb, rdSeen, bufCongested, pauseFilterEn} = '0;
    addr = '0;
    wrData = '0;
    modeStrapPin = 1'b1;
    typeStrapPin = IF_RMII;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ad(IDX_XMII_CTL0), 8'h50);
    rd(ad(IDX_XMII_CTL1), 8'h0d);
    rd(ad(IDX_MAC_CTL0), 8'h00);
    rd(ad(IDX_MAC_CTL1), 8'h00);
    rd(ad(IDX_STATUS), 8'h99);
    settle();
    `CHK({fullDuplex, speedSel, ifType}, {1'b1, SPD_1000, IF_RMII})
    `CHK({rxClkPinOe, refClkGenEn}, 2'b00)
    done("reset");
    wr(ad(IDX_XMII_CTL0), 8'hff);
    wr(ad(IDX_XMII_CTL1), 8'hff);
    wr(ad(IDX_MAC_CTL0), 8'hff);
    wr(ad(IDX_MAC_CTL1), 8'hff);
    rd(ad(IDX_XMII_CTL0), 8'h7f);
    rd(ad(IDX_XMII_CTL1), 8'hff);
    rd(ad(IDX_MAC_CTL0), 8'h0b);
    rd(ad(IDX_MAC_CTL1), 8'hbf);
    rd(ad(14'h0005), 8'h00);
    rd(ad(IDX_XMII_CTL0) | 16'h0001, 8'h00);
    wr(ad(IDX_XMII_CTL1), 8'hfe);
    rd(ad(IDX_XMII_CTL1), 8'hff);
    settle();
    `CHK({speedSel, ifType}, {SPD_100, IF_RGMII})
    `CHK({rxClockDelayEnable, txClockDelayEnable, jumboEn}, 3'h7)
    done("access");
    // the reserved code must leave the previous type in place
    for (int i = 0; i < 8; i++) begin
      t = i[2:1];
      m = i[0];
      wr(ad(IDX_XMII_CTL1), {5'h00, m, t});
      settle();
      if (t == IF_RSVD) t = IF_RMII;
      v = {3'h0, t, t == IF_MII && m, t != IF_RGMII && !m, t == IF_RMII && !m};
      `CHK({ifType, miiMacMode, rxClkPinOe, refClkGenEn}, v[4:0])
      `CHK(rxClkPinOe ^ ptnClkOe, 1'b1)
    end
    wr(ad(IDX_XMII_CTL1), 8'h13);
    settle();
    `CHK({rxClockDelayEnable, txClockDelayEnable}, 2'b10)
    wr(ad(IDX_XMII_CTL1), 8'h0b);
    settle();
    `CHK({rxClockDelayEnable, txClockDelayEnable}, 2'b01)
    for (int s = 0; s < 4; s++) begin
      wr(ad(IDX_XMII_CTL0), {3'h0, s[0], 4'h0});
      wr(ad(IDX_XMII_CTL1), {1'b0, s[1], 6'h03});
      settle();
      `CHK(speedSel, s[1] ? (s[0] ? SPD_100 : SPD_10) : SPD_1000)
    end
    repeat (8) begin
      v = 8'($random(seed));
      wr(ad(IDX_XMII_CTL0), v);
      rd(ad(IDX_XMII_CTL0), v & 8'h7f);
      settle();
      `CHK({fullDuplex, speedSel}, {v[6], 1'b0, v[4]})
    end
    done("modes");
    wr(ad(IDX_XMII_CTL0), 8'h68);
    wr(ad(IDX_MAC_CTL1), 8'h08);
    congest(2'b10);
    wr(ad(IDX_XMII_CTL0), 8'h08);
    congest(2'b01);
    wr(ad(IDX_MAC_CTL1), 8'h00);
    congest(2'b00);
    wr(ad(IDX_XMII_CTL0), 8'h48);
    congest(2'b00);
    ptn.setPause(1'b1);
    settle();
    `CHK(txHold, 1'b1)
    wr(ad(IDX_XMII_CTL0), 8'h40);
    settle();
    `CHK(txHold, 1'b0)
    ptn.setPause(1'b0);
    wr(ad(IDX_MAC_CTL0), 8'h00);
    settle();
    done("flow");
    pauseFilterEn <= 1'b1;
    frm(63, 0, 0, 0, DRP);
    repeat (4) frm(64, 0, 1, 0, FWD);
    frm(1518, 0, 0, 0, FWD);
    frm(1519, 0, 0, 0, DRP);
    frm(100, 1, 0, 0, DRP);
    frm(64, 1, 0, 1, DRP);
    pauseFilterEn <= 1'b0;
    frm(64, 1, 0, 1, FWD);
    wr(ad(IDX_MAC_CTL1), 8'h01);
    settle();
    frm(63, 0, 0, 0, MIR);
    frm(1519, 0, 0, 0, MIR);
    frm(100, 1, 0, 0, MIR);
    frm(64, 1, 0, 1, FWD);
    wr(ad(IDX_MAC_CTL1), 8'h00);
    wr(ad(IDX_MAC_CTL0), 8'h01);
    settle();
    frm(9018, 0, 0, 0, FWD);
    frm(9019, 0, 0, 0, DRP);
    settle();
    `CHK(vQ.size(), 0)
    done("frames");
    // storm window restarts with the link reset, so the third broadcast falls in it
    reset_n <= 1'b0;
    {modeStrapPin, typeStrapPin} <= {1'b0, IF_MII};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ad(IDX_XMII_CTL1), 8'h08);
    rd(ad(IDX_STATUS), 8'hd8);
    wr(ad(IDX_MAC_CTL0), 8'h02);
    settle();
    repeat (2) frm(64, 0, 1, 0, FWD);
    frm(64, 0, 1, 0, DRP);
    frm(64, 0, 0, 0, FWD);
    settle();
    `CHK(vQ.size(), 0)
    done("storm");
    report_and_stop();
  end
endmodule
`default_nettype wire
